// >>> rtl/radio_status_indicator_logic.sv
// Decided for this implementation: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "status_ind_consts.svh"
module radio_status_indicator_logic
  import status_ind_pkg::*;
#(
  // timing counts in clock cycles; a bench may shrink them to keep runs short
  parameter int unsigned SLOW_HALF = `SLOW_HALF_CYCLES,
  parameter int unsigned QUICK_HALF = `QUICK_HALF_CYCLES,
  parameter int unsigned FLICK_HALF = `FLICK_HALF_CYCLES,
  parameter int unsigned FLICK_HOLD = `FLICK_HOLD_CYCLES
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic bus_variant,
  input wire logic radio_linked,
  input wire logic serial_cabled,
  input wire logic serial_txd_activity,
  input wire logic rf_tx_activity,
  input wire logic rf_rx_activity,
  input wire logic [7:0] signal_level_neg_db,
  input wire logic config_write_req,
  input wire logic payload_tx_req,
  input wire logic payload_rx_req,
  output logic radio_link_indicator,
  output logic tx_led,
  output logic rx_led,
  output logic sleep_led,
  output logic config_write_grant,
  output logic payload_tx_grant,
  output logic payload_rx_grant
);

  // every flop of the block lives in this record, so one reset clause covers all
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] rdata;
    logic wr_pend;
    logic [11:0] wr_addr;
    logic [27:0] slow_cnt;
    logic slow_lvl;
    logic [27:0] quick_cnt;
    logic quick_lvl;
    logic [2:0] flash_cnt;
    link_seq_t seq;
    flick_t tx_f;
    flick_t rx_f;
    logic link_led;
    logic tx_o;
    logic rx_o;
    logic sleep_o;
    logic cfg_g;
    logic ptx_g;
    logic prx_g;
    logic rdy;
    logic err;
  } state_t;

  state_t state_reg;
  state_t state_next;

  radio_mode_t mode;
  logic sleep_mode;
  logic emul_mode;
  logic group_bad;
  logic tx_act;
  logic slow_tick;

  // the spare mode code gets no branch of its own and behaves as a slave
  assign mode = radio_mode_t'(state_reg.ctrl[`CTRL_MODE_LSB +: 2]);
  assign sleep_mode = state_reg.ctrl[`CTRL_SLEEP_BIT];
  assign emul_mode = state_reg.ctrl[`CTRL_EMUL_BIT];
  // the all-zero network_group_identifier is the factory value and never a valid network
  assign group_bad = state_reg.ctrl[`CTRL_GROUP_LSB +: 16] == `ILLEGAL_NETWORK_GROUP_IDENTIFIER;
  // on the bus variant the serial txd line triggers the tx LED, not the radio
  assign tx_act = bus_variant ? serial_txd_activity : rf_tx_activity;
  // one shared slow base keeps the link blink and the sleep flash in step
  assign slow_tick = state_reg.slow_cnt == 28'(SLOW_HALF - 1);

  // one flicker channel; the hold keeps it going across short gaps in activity
  function automatic flick_t flick_step(input flick_t f, input logic act);
    flick_t n;
    n = f;
    if (act)
    begin
      // restart on every pulse so the pattern stays visibly rapid
      n.active = 1'b1;
      n.flick_hold = 28'h0000000;
    end
    else if (f.active)
    begin
      if (f.flick_hold == 28'(FLICK_HOLD - 1))
      begin
        n.active = 1'b0;
      end
      else
      begin
        n.flick_hold = f.flick_hold + 28'h0000001;
      end
    end
    if (n.active)
    begin
      if (f.flick_half == 28'(FLICK_HALF - 1))
      begin
        n.flick_half = 28'h0000000;
        n.lvl = ~f.lvl;
      end
      else
      begin
        n.flick_half = f.flick_half + 28'h0000001;
      end
    end
    else
    begin
      // an idle channel parks high so the LED reads steady on
      n.flick_half = 28'h0000000;
      n.lvl = 1'b1;
    end
    return n;
  endfunction

  always_comb
  begin
    logic [11:0] a;
    logic take;
    logic slow_led;
    a = haddr[11:0];
    take = hsel && hready && htrans[1];
    slow_led = state_reg.slow_lvl;
    state_next = state_reg;

    // zero wait states and never an error; flopped so every output is registered
    state_next.rdy = 1'b1;
    state_next.err = 1'b0;

    // write data phase: hwdata only stands one cycle after the address
    state_next.wr_pend = take && hwrite;
    state_next.wr_addr = a;
    // only the control word is writable; other writes are dropped
    if (state_reg.wr_pend && state_reg.wr_addr == `ADDR_CTRL)
    begin
      state_next.ctrl = hwdata;
    end
    // read data is caught in the address phase and stands until the next read
    if (take && !hwrite)
    begin
      if (a == `ADDR_CTRL)
      begin
        state_next.rdata = state_reg.ctrl;
      end
      else if (a == `ADDR_STATUS)
      begin
        // live snapshot of the inputs and LED flops for diagnostics
        state_next.rdata = {25'h0000000, state_reg.sleep_o, state_reg.rx_o, state_reg.tx_o,
                            state_reg.link_led, group_bad, radio_linked, serial_cabled};
      end
      else if (a == `ADDR_STRENGTH)
      begin
        // magnitude only; zero on master or outside emulation mode
        if (emul_mode && mode != MODE_MASTER)
        begin
          state_next.rdata = {24'h000000, signal_level_neg_db};
        end
        else
        begin
          state_next.rdata = 32'h0000_0000;
        end
      end
      else
      begin
        state_next.rdata = 32'h0000_0000;
      end
    end

    // slow blink base: toggles once per second, one flash per 2 s
    if (slow_tick)
    begin
      state_next.slow_cnt = 28'h0000000;
      state_next.slow_lvl = ~state_reg.slow_lvl;
    end
    else
    begin
      state_next.slow_cnt = state_reg.slow_cnt + 28'h0000001;
    end

    // quick flash burst sequencer
    if (state_reg.quick_cnt == 28'(QUICK_HALF - 1))
    begin
      state_next.quick_cnt = 28'h0000000;
    end
    else
    begin
      state_next.quick_cnt = state_reg.quick_cnt + 28'h0000001;
    end
    case (state_reg.seq)
      LS_NORMAL:
      begin
        // a bad id starts its burst at once, without waiting for the slow base
        state_next.quick_lvl = 1'b0;
        state_next.flash_cnt = 3'h0;
        if (group_bad)
        begin
          state_next.seq = LS_BURST;
          state_next.quick_cnt = 28'h0000000;
        end
      end
      LS_BURST:
      begin
        // a legal network_group_identifier cuts the burst short, so steady modes are not held off
        if (!group_bad)
        begin
          state_next.seq = LS_NORMAL;
        end
        else if (state_reg.quick_cnt == 28'(QUICK_HALF - 1))
        begin
          state_next.quick_lvl = ~state_reg.quick_lvl;
          if (state_reg.quick_lvl)
          begin
            state_next.flash_cnt = state_reg.flash_cnt + 3'h1;
            if (state_reg.flash_cnt == 3'(`QUICK_FLASH_COUNT - 1))
            begin
              state_next.seq = LS_GAP;
            end
          end
        end
      end
      LS_GAP:
      begin
        // dark until the slow base falls, so bursts repeat once per slow period
        state_next.quick_lvl = 1'b0;
        state_next.flash_cnt = 3'h0;
        if (!group_bad)
        begin
          state_next.seq = LS_NORMAL;
        end
        else if (slow_tick && state_reg.slow_lvl)
        begin
          state_next.seq = LS_BURST;
          state_next.quick_cnt = 28'h0000000;
        end
      end
      default:
      begin
        state_next.seq = LS_NORMAL;
      end
    endcase

    if (state_reg.seq != LS_NORMAL)
    begin
      state_next.link_led = state_reg.quick_lvl;
    end
    else if (mode == MODE_MASTER)
    begin
      state_next.link_led = 1'b1;
    end
    else if (mode == MODE_REPEATER)
    begin
      state_next.link_led = radio_linked ? 1'b1 : slow_led;
    end
    else
    begin
      state_next.link_led = radio_linked ? 1'b1 : slow_led;
    end

    // both indicators share one flicker engine; only the trigger differs
    state_next.tx_f = flick_step(state_reg.tx_f, tx_act);
    state_next.rx_f = flick_step(state_reg.rx_f, rf_rx_activity);
    // missing cabling overrides flicker, so a steadily dark tx LED always points at cabling
    if (!serial_cabled)
    begin
      state_next.tx_o = 1'b0;
    end
    else if (state_reg.tx_f.active)
    begin
      state_next.tx_o = state_reg.tx_f.lvl;
    end
    else
    begin
      state_next.tx_o = 1'b1;
    end
    // rx has no cabling condition; powered and idle means lit
    state_next.rx_o = state_reg.rx_f.active ? state_reg.rx_f.lvl : 1'b1;

    // short blip at the start of each 2 s period while asleep on the bus variant
    // the blip borrows the quick flash length so it stays visible
    if (!bus_variant)
    begin
      state_next.sleep_o = 1'b0;
    end
    else if (sleep_mode)
    begin
      state_next.sleep_o = state_reg.slow_lvl && state_reg.quick_cnt[27:25] == 3'h0 &&
                           state_reg.slow_cnt < 28'(QUICK_HALF);
    end
    else
    begin
      state_next.sleep_o = 1'b1;
    end

    // grants lag their requests by one cycle and drop while asleep
    state_next.cfg_g = config_write_req && !sleep_mode;
    state_next.ptx_g = payload_tx_req && !sleep_mode;
    state_next.prx_g = payload_rx_req && !sleep_mode;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg <= '0;
      state_reg.ctrl <= `CTRL_RESET;
      state_reg.seq <= LS_NORMAL;
      // ready stays high in reset, as an idle slave is expected to show
      state_reg.rdy <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign hreadyout = state_reg.rdy;
  assign hresp = state_reg.err;
  assign hrdata = state_reg.rdata;
  assign radio_link_indicator = state_reg.link_led;
  assign tx_led = state_reg.tx_o;
  assign rx_led = state_reg.rx_o;
  assign sleep_led = state_reg.sleep_o;
  assign config_write_grant = state_reg.cfg_g;
  assign payload_tx_grant = state_reg.ptx_g;
  assign payload_rx_grant = state_reg.prx_g;

endmodule // radio_status_indicator_logic

// >>> rtl/status_ind_consts.svh
`ifndef STATUS_IND_CONSTS_SVH
`define STATUS_IND_CONSTS_SVH
// Summary of operation
// - sleep LED on, flashes every two seconds asleep (bus variant only, else dark)
// - sleep blocks programming and payload data
// - master keeps link LED steadily on
// - unlinked slave blinks link LED every 2 s
// - slave link LED steady once linked
// - repeater blinks unlinked, steady when linked
// - illegal network_group_identifier gives 5 quick flashes
// - tx LED off without proper serial cabling
// - tx LED steady when cabled and idle
// - tx LED flickers while radio transmits (non-bus variant)
// - tx flicker driven from serial transmit line on bus variant
// - rx LED flickers receiving, else steady on
// - strength register holds magnitude in dB
// - strength readable only in controller emulation mode
// - master provides no signal strength

`define CLK_FREQ_HZ 125000000
// slow blink: 2 s period, 2 s = 250,000,000 cycles, halved for on/off
`define SLOW_PERIOD_MS 2000
`define SLOW_HALF_CYCLES ((`CLK_FREQ_HZ / 1000) * `SLOW_PERIOD_MS / 2)
// quick flash: 100 ms per half period
`define QUICK_HALF_MS 100
`define QUICK_HALF_CYCLES ((`CLK_FREQ_HZ / 1000) * `QUICK_HALF_MS)
// flicker: 25 ms half period, held 100 ms after last activity
`define FLICK_HALF_MS 25
`define FLICK_HALF_CYCLES ((`CLK_FREQ_HZ / 1000) * `FLICK_HALF_MS)
`define FLICK_HOLD_MS 100
`define FLICK_HOLD_CYCLES ((`CLK_FREQ_HZ / 1000) * `FLICK_HOLD_MS)
`define QUICK_FLASH_COUNT 5
`define ILLEGAL_NETWORK_GROUP_IDENTIFIER 16'h0000

`define ADDR_CTRL 12'h000
`define ADDR_STATUS 12'h004
`define ADDR_STRENGTH 12'h008
`define CTRL_MODE_LSB 0
`define CTRL_EMUL_BIT 2
`define CTRL_SLEEP_BIT 3
`define CTRL_GROUP_LSB 16
`define CTRL_RESET 32'h0000_0000
`endif

// >>> rtl/status_ind_pkg.sv
package status_ind_pkg;
  typedef enum logic [1:0] {MODE_MASTER, MODE_REPEATER, MODE_SLAVE, MODE_SPARE} radio_mode_t;
  typedef enum logic [1:0] {LS_NORMAL, LS_BURST, LS_GAP} link_seq_t;
  typedef struct packed {
    logic [27:0] flick_half;
    logic [27:0] flick_hold;
    logic active;
    logic lvl;
  } flick_t;
endpackage

// >>> testbench/radio_far_side.sv
`timescale 1ns/1ps
module radio_far_side (
  input wire logic hclk,
  input wire logic [2:0] act_en,
  output logic rf_tx_activity = 1'b0,
  output logic rf_rx_activity = 1'b0,
  output logic serial_txd_activity = 1'b0
);
  int seed = 93373;
  logic [2:0] r;
  // irregular bursts, gaps kept short so activity looks continuous
  always @(posedge hclk)
  begin
    r = 3'($random(seed));
    rf_tx_activity <= act_en[0] & r[0];
    rf_rx_activity <= act_en[1] & r[1];
    serial_txd_activity <= act_en[2] & r[2];
  end
endmodule // radio_far_side

// >>> testbench/status_ind_props.sv
`timescale 1ns/1ps
module status_ind_props #(
  parameter int unsigned SLOW_HALF = 40,
  parameter int unsigned FLICK_HALF = 2,
  parameter int unsigned FLICK_HOLD = 8
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic bus_variant,
  input wire logic radio_linked,
  input wire logic serial_cabled,
  input wire logic serial_txd_activity,
  input wire logic rf_tx_activity,
  input wire logic rf_rx_activity,
  input wire logic [7:0] signal_level_neg_db,
  input wire logic config_write_req,
  input wire logic radio_link_indicator,
  input wire logic tx_led,
  input wire logic rx_led,
  input wire logic sleep_led,
  input wire logic config_write_grant,
  input wire logic payload_tx_grant,
  input wire logic payload_rx_grant
);
  localparam int unsigned IDLE_MIN = FLICK_HOLD + FLICK_HALF + 4;
  logic wa, ra, ok, acc;
  logic [31:0] ctrl;
  int unsigned age, ic, rc, bc;
  // shadow of the control word, so mode-dependent checks see what software set
  assign acc = hsel && hready && htrans[1];
  assign ok = age > 3 && !ctrl[3] && ctrl[31:16] != 16'h0000;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      {wa, ra, ctrl, age, ic, rc, bc} <= '0;
    end
    else
    begin
      wa <= acc && hwrite && haddr == 32'h0000_0000;
      ra <= acc && !hwrite && haddr == 32'h0000_0008;
      ctrl <= wa ? hwdata : ctrl;
      age <= wa ? 0 : age + 1;
      ic <= (serial_cabled && !serial_txd_activity && !rf_tx_activity) ? ic + 1 : 0;
      rc <= rf_rx_activity ? 0 : rc + 1;
      bc <= (ok && ctrl[1:0] != 2'b00 && !radio_linked && $stable(radio_link_indicator)) ?
        bc + 1 : 0;
    end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready with okay");
  a_strength_value: assert property (ra |-> hrdata == ((ctrl[2] && ctrl[1:0] != 2'b00) ?
    {24'h000000, $past(signal_level_neg_db)} : 32'h0000_0000))
    else $error("signal strength read wrong");
  a_sleep_gates: assert property (age > 2 && ctrl[3] |->
    !config_write_grant && !payload_tx_grant && !payload_rx_grant)
    else $error("grant while asleep");
  a_grant_cause: assert property (config_write_grant |-> $past(config_write_req))
    else $error("config grant without request");
  a_master_link: assert property (ok && ctrl[1:0] == 2'b00 |-> radio_link_indicator)
    else $error("master link indicator not steady");
  a_linked_steady: assert property (ok && ctrl[1:0] != 2'b00 && radio_linked &&
    $past(radio_linked) && $past(radio_linked, 2) |-> radio_link_indicator)
    else $error("linked indicator not steady");
  a_unlinked_blink: assert property (bc <= SLOW_HALF + 2)
    else $error("unlinked indicator stopped blinking");
  a_tx_off: assert property (!serial_cabled [*3] |-> !tx_led)
    else $error("tx led lit without cabling");
  a_tx_steady: assert property (ic > IDLE_MIN |-> tx_led)
    else $error("tx led not steady when idle");
  a_rx_steady: assert property (rc > IDLE_MIN |-> rx_led)
    else $error("rx led not steady when idle");
  a_rx_flicker: assert property (rf_rx_activity [*3] |-> ##[0:6] $changed(rx_led))
    else $error("rx led not flickering");
  a_sleep_on: assert property (age > 3 && !ctrl[3] && bus_variant && $past(bus_variant)
    |-> sleep_led)
    else $error("sleep led dark while awake");
endmodule // status_ind_props
bind radio_status_indicator_logic status_ind_props #(.SLOW_HALF(SLOW_HALF),
  .FLICK_HALF(FLICK_HALF), .FLICK_HOLD(FLICK_HOLD)) chk (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .bus_variant,
  .radio_linked, .serial_cabled, .serial_txd_activity, .rf_tx_activity, .rf_rx_activity,
  .signal_level_neg_db, .config_write_req, .radio_link_indicator, .tx_led, .rx_led,
  .sleep_led, .config_write_grant, .payload_tx_grant, .payload_rx_grant);

// >>> testbench/tb.sv
`timescale 1ns/1ps
`include "status_ind_consts.svh"
`define CHK(nm, ex, gt) \
  begin \
    total_checks++; \
    if ((gt) !== (ex)) \
    begin \
      $display("CHECK FAILED %s exp %0h got %0h", nm, ex, gt); \
      fail_count++; \
    end \
  end
module tb;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'b00, m;
  logic [2:0] hsize = 3'b010, act_en = 3'b000, k;
  logic [7:0] signal_level_neg_db = 8'h00;
  logic [15:0] grp;
  logic bus_variant = 1'b0, radio_linked = 1'b0, serial_cabled = 1'b0;
  logic config_write_req = 1'b0, payload_tx_req = 1'b0, payload_rx_req = 1'b0;
  logic hreadyout, hresp, radio_link_indicator, tx_led, rx_led, sleep_led;
  logic config_write_grant, payload_tx_grant, payload_rx_grant;
  logic rf_tx_activity, rf_rx_activity, serial_txd_activity;
  logic [3:0] leds;
  int fail_count = 0, total_checks = 0, seed = 93373, n;
  assign hready = hreadyout;
  assign leds = {sleep_led, rx_led, tx_led, radio_link_indicator};
  initial forever #4 hclk = ~hclk;
  radio_status_indicator_logic #(.SLOW_HALF(40), .QUICK_HALF(4), .FLICK_HALF(2),
    .FLICK_HOLD(8)) uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .bus_variant, .radio_linked, .serial_cabled,
    .serial_txd_activity, .rf_tx_activity, .rf_rx_activity, .signal_level_neg_db,
    .config_write_req, .payload_tx_req, .payload_rx_req, .radio_link_indicator, .tx_led,
    .rx_led, .sleep_led, .config_write_grant, .payload_tx_grant, .payload_rx_grant);
  radio_far_side far (.hclk, .act_en, .rf_tx_activity, .rf_rx_activity, .serial_txd_activity);
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wait_rdy;
    int i;
    i = 0;
    do
    begin
      @(posedge hclk);
      i++;
    end
    while (hready !== 1'b1 && i < 20);
    `CHK("hready wait", 1'b1, hready)
    if (hready !== 1'b1)
      conclude();
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {20'h00000, a};
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask
  // counts rising edges of one led over two slow periods
  task automatic rises(input int j, output int c);
    logic p;
    c = 0;
    p = leds[j];
    repeat (160)
    begin
      @(negedge hclk);
      c += (leds[j] && !p) ? 1 : 0;
      p = leds[j];
    end
    @(posedge hclk);
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge hclk);
  endtask
  initial
  begin
    repeat (90000) @(posedge hclk);
    `CHK("run time", 1'b1, 1'b0)
    conclude();
  end
  initial
  begin
    grp = 16'($random(seed)) | 16'h0001;
    wt(6);
    hresetn <= 1'b1;
    wt(1);
    bus(1'b0, `ADDR_CTRL, 32'h0);
    `CHK("ctrl reset", 32'h0000_0000, rd)
    bus(1'b0, 12'h010, 32'h0);
    `CHK("unmapped read", 32'h0000_0000, rd)
    for (m = 0; m < 3; m++)
    begin
      bus(1'b1, `ADDR_CTRL, {16'h0000, 14'h0000, m});
      wt(100);
      rises(0, n);
      `CHK("bad group flashes", 10, n)
      bus(1'b1, `ADDR_CTRL, {grp, 14'h0000, m});
      radio_linked <= 1'b0;
      wt(100);
      rises(0, n);
      `CHK("unlinked rises", (m == 2'b00) ? 0 : 2, n)
      radio_linked <= 1'b1;
      wt(4);
      rises(0, n);
      `CHK("linked rises", 0, n)
      `CHK("linked led", 1'b1, radio_link_indicator)
    end
    $display("link indicator test done");
    act_en <= 3'b001;
    wt(20);
    rises(1, n);
    `CHK("uncabled tx rises", 0, n)
    `CHK("uncabled tx led", 1'b0, tx_led)
    serial_cabled <= 1'b1;
    act_en <= 3'b000;
    wt(20);
    `CHK("idle tx led", 1'b1, tx_led)
    act_en <= 3'b001;
    rises(1, n);
    `CHK("rf tx flicker", 1'b1, n > 10)
    bus_variant <= 1'b1;
    wt(20);
    rises(1, n);
    `CHK("txd idle rises", 0, n)
    act_en <= 3'b100;
    rises(1, n);
    `CHK("txd flicker", 1'b1, n > 10)
    act_en <= 3'b010;
    rises(2, n);
    `CHK("rx flicker", 1'b1, n > 10)
    act_en <= 3'b000;
    wt(20);
    `CHK("idle rx led", 1'b1, rx_led)
    $display("activity test done");
    signal_level_neg_db <= 8'($random(seed));
    for (k = 0; k < 4; k++)
    begin
      bus(1'b1, `ADDR_CTRL, {grp, 13'h0000, k[0], k[1] ? 2'b00 : 2'b10});
      bus(1'b0, `ADDR_STRENGTH, 32'h0);
      `CHK("strength", (k[0] && !k[1]) ? {24'h0, signal_level_neg_db} : 32'h0, rd)
    end
    bus(1'b0, `ADDR_STATUS, 32'h0);
    `CHK("status word", 32'h0000_007B, rd)
    $display("strength test done");
    `CHK("awake sleep led", 1'b1, sleep_led)
    {config_write_req, payload_tx_req, payload_rx_req} <= 3'b111;
    wt(3);
    `CHK("awake grants", 3'b111, {config_write_grant, payload_tx_grant, payload_rx_grant})
    bus(1'b1, `ADDR_CTRL, {grp, 12'h000, 4'b1010});
    wt(100);
    rises(3, n);
    `CHK("sleep flashes", 2, n)
    `CHK("sleep grants", 3'b000, {config_write_grant, payload_tx_grant, payload_rx_grant})
    $display("sleep test done");
    conclude();
  end
endmodule // tb
